// >>> shared/io_out_map.vh
// Purpose: constants for the output path cell and its register map
// Assumes: 32-bit Avalon-MM word addressing by byte address
// Notes: none
`ifndef IO_OUT_MAP_VH
`define IO_OUT_MAP_VH
`define CFG_ADDR 4'h0
`define CTRL_ADDR 4'h4
`define STAT_ADDR 4'h8
`define CFG_OUT_INV 0
`define CFG_TRI_INV 1
`define CFG_REG_SEL 2
`define CFG_INIT_SET 3
`define CFG_CE_OUT 4
`define CFG_CE_IN 5
`define CTRL_OUT 0
`define CTRL_TRI 1
`define CTRL_CE 2
`define CTRL_CE_DRIVEN 3
`define CTRL_TRI_DRIVEN 4
`define CTRL_GLOBAL_SET_RESET 5
`define CFG_WIDTH 6
`define CTRL_WIDTH 6
`define STAT_PAD_OUT 0
`define STAT_PAD_OE 1
`define STAT_CAPTURE 2
`define STAT_PAD_SYNC 3
`define BE_LANE0 0
`define CFG_RESET 6'h00
`define CTRL_RESET 6'h00
`define WAIT_RESET 1'h1
`define PIN_RESET 1'h0
`define CE_IDLE_LEVEL 1'h1
`define TRI_IDLE_LEVEL 1'h0
`define RDATA_ZERO 32'h0000_0000
`define UNMAPPED_DATA 32'h0000_0000
`endif

// >>> hdl/out_flop.v
// Purpose: output storage flip-flop with clock enable and init value
// Assumes: init asserted forces the configured init value
// Notes: init wins over enable
`timescale 1ns/1ps
module out_flop (
  input wire clk,
  input wire init,
  input wire init_val,
  input wire ce,
  input wire d,
  output reg q
);
  always @(posedge clk) begin
    if (init) begin
      q <= init_val;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule // out_flop

// >>> hdl/io_output_path_register.v
// Purpose: output path of one I/O cell, configured over Avalon-MM
// Assumes: one clock; srst doubles as power-up init
// Notes: writes answer with waitrequest low in the second cycle
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "io_out_map.vh"
module io_output_path_register (
  input wire clk,
  input wire srst,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire pad_in,
  output reg pad_out,
  output reg pad_oe,
  output reg in_capture_r
);
  // handshake states of the slave side
  localparam [0:0] BUS_IDLE = 1'h0;
  localparam [0:0] BUS_ANSWER = 1'h1;
  localparam CFG_W = `CFG_WIDTH;
  localparam CTRL_W = `CTRL_WIDTH;

  ////////////////////////////////////////////////////////////////
  // helpers

  // one address compare serves both the write decode and the read mux
  function addr_hit;
    input [3:0] addr;
    input [3:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // polarity select: a set invert bit flips the signal
  function apply_polarity;
    input value;
    input invert;
    begin
      apply_polarity = value ^ invert;
    end
  endfunction

  // a control left undriven falls back to its idle level
  function driven_or_default;
    input driven;
    input value;
    input idle_level;
    begin
      driven_or_default = driven ? value : idle_level;
    end
  endfunction

  // every defined field sits in byte lane 0; other lanes are ignored
  function lane0_write;
    input wr;
    input [3:0] be;
    begin
      lane0_write = wr & be[`BE_LANE0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // state

  reg [CFG_W-1:0] cfg_r;
  reg [CFG_W-1:0] cfg_nxt;
  reg [CTRL_W-1:0] ctrl_r;
  reg [CTRL_W-1:0] ctrl_nxt;
  reg bus_state_r;
  reg bus_state_nxt;
  reg waitrequest_nxt;
  reg [31:0] rd_word;
  reg [31:0] readdata_nxt;
  reg pad_out_nxt;
  reg pad_oe_nxt;
  reg capture_nxt;
  reg pad_s1_r;
  reg pad_s2_r;
  wire request;
  wire take;
  wire complete;
  wire wr_lane0;
  wire out_q;
  wire logic_cell_clock_enable;
  wire tri_ctl;
  wire tri_eff;
  wire out_eff;
  wire global_set_reset_net;
  wire flop_init_value;
  wire out_flop_ce;
  wire in_elem_ce;

  ////////////////////////////////////////////////////////////////
  // bus slave: a request is taken on its first edge and answered on the next
  // no back-pressure beyond that one wait cycle; a request dropped early is abandoned

  assign request = read | write;
  assign take = request & (bus_state_r == BUS_IDLE);
  assign complete = request & (bus_state_r == BUS_ANSWER);
  assign wr_lane0 = lane0_write(write, byteenable);

  always @* begin
    bus_state_nxt = bus_state_r;
    waitrequest_nxt = `WAIT_RESET;
    case (bus_state_r)
      BUS_IDLE: begin
        if (request) begin
          bus_state_nxt = BUS_ANSWER;
          waitrequest_nxt = ~`WAIT_RESET;
        end
      end
      BUS_ANSWER: begin
        // master sees waitrequest low on this edge and drops the request after it
        bus_state_nxt = BUS_IDLE;
      end
      default: begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  // read word from the live registers; unmapped offsets read as a fixed word
  always @* begin
    rd_word = `RDATA_ZERO;
    if (addr_hit(address, `CFG_ADDR)) begin
      rd_word[CFG_W-1:0] = cfg_r;
    end else if (addr_hit(address, `CTRL_ADDR)) begin
      rd_word[CTRL_W-1:0] = ctrl_r;
    end else if (addr_hit(address, `STAT_ADDR)) begin
      rd_word[`STAT_PAD_OUT] = pad_out;
      rd_word[`STAT_PAD_OE] = pad_oe;
      rd_word[`STAT_CAPTURE] = in_capture_r;
      rd_word[`STAT_PAD_SYNC] = pad_s2_r;
    end else begin
      rd_word = `UNMAPPED_DATA;
    end
  end

  // read data is captured when the request is taken and stands until the next one
  always @* begin
    readdata_nxt = readdata;
    if (take) begin
      readdata_nxt = rd_word;
    end
  end

  // a write lands on the edge at which the master sees waitrequest low
  always @* begin
    cfg_nxt = cfg_r;
    ctrl_nxt = ctrl_r;
    if (complete & wr_lane0) begin
      if (addr_hit(address, `CFG_ADDR)) begin
        cfg_nxt = writedata[CFG_W-1:0];
      end
      if (addr_hit(address, `CTRL_ADDR)) begin
        ctrl_nxt = writedata[CTRL_W-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      waitrequest <= `WAIT_RESET;
    end else begin
      waitrequest <= waitrequest_nxt;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      readdata <= `RDATA_ZERO;
    end else begin
      readdata <= readdata_nxt;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      cfg_r <= `CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      ctrl_r <= `CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // output path

  // undriven enable reads high, undriven tristate reads low
  assign logic_cell_clock_enable = driven_or_default(ctrl_r[`CTRL_CE_DRIVEN],
    ctrl_r[`CTRL_CE], `CE_IDLE_LEVEL);
  assign tri_ctl = driven_or_default(ctrl_r[`CTRL_TRI_DRIVEN],
    ctrl_r[`CTRL_TRI], `TRI_IDLE_LEVEL);

  // inversions sit ahead of the flop and of the driver enable
  assign out_eff = apply_polarity(ctrl_r[`CTRL_OUT], cfg_r[`CFG_OUT_INV]);
  assign tri_eff = apply_polarity(tri_ctl, cfg_r[`CFG_TRI_INV]);

  // one enable, gated separately towards the output flop and the input element
  assign out_flop_ce = logic_cell_clock_enable & cfg_r[`CFG_CE_OUT];
  assign in_elem_ce = logic_cell_clock_enable & cfg_r[`CFG_CE_IN];

  // srst stands in for power-up; the control bit is a held level, so the flop
  // stays at its init value for as long as software keeps it set
  assign global_set_reset_net = srst | ctrl_r[`CTRL_GLOBAL_SET_RESET];
  assign flop_init_value = cfg_r[`CFG_INIT_SET];

  // init wins over enable inside the flop
  out_flop u_flop (
    .clk(clk),
    .init(global_set_reset_net),
    .init_val(flop_init_value),
    .ce(out_flop_ce),
    .d(out_eff),
    .q(out_q)
  );

  // registered path shows the flop, direct path the live value
  always @* begin
    pad_out_nxt = out_eff;
    if (cfg_r[`CFG_REG_SEL]) begin
      pad_out_nxt = out_q;
    end
  end

  // tristate high releases the pad whatever the flop holds
  always @* begin
    pad_oe_nxt = ~tri_eff;
  end

  // pad registered here so every output comes from a flop; costs one cycle
  always @(posedge clk) begin
    if (srst) begin
      pad_out <= `PIN_RESET;
    end else begin
      pad_out <= pad_out_nxt;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pad_oe <= `PIN_RESET;
    end else begin
      pad_oe <= pad_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // input side

  // the pad is asynchronous to clk; only the second stage feeds logic
  always @(posedge clk) begin
    if (srst) begin
      pad_s1_r <= `PIN_RESET;
      pad_s2_r <= `PIN_RESET;
    end else begin
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
    end
  end

  // the input element keeps what the synchroniser showed when the enable last fired
  always @* begin
    capture_nxt = in_capture_r;
    if (in_elem_ce) begin
      capture_nxt = pad_s2_r;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      in_capture_r <= `PIN_RESET;
    end else begin
      in_capture_r <= capture_nxt;
    end
  end
endmodule // io_output_path_register

// >>> dv/pad_model.sv
// Purpose: pad and board line. Assumes: pull-up. Notes: none
`timescale 1ns/1ps
module pad_model(input wire pad_out, input wire pad_oe, output wire pad_in);
  assign pad_in = pad_oe ? pad_out : 1'b1;
endmodule // pad_model

// >>> dv/io_out_assertions.sv
// Purpose: port checks. Assumes: one clock. Notes: config is unseen
`timescale 1ns/1ps
module io_out_chk(input wire clk, input wire srst, input wire [3:0] address,
  input wire read, input wire write, input wire [31:0] readdata, input wire waitrequest,
  input wire pad_out, input wire pad_oe, input wire in_capture_r);
  default clocking @(posedge clk); endclocking
  a_wait_one: assert property (disable iff (srst) !waitrequest |=> waitrequest) else $error("wait");
  a_wait_bound: assert property (disable iff (srst) (read || write) && waitrequest
    |-> ##[0:2] !waitrequest) else $error("no answer");
  a_idle_wait: assert property (disable iff (srst) !read && !write |=> waitrequest) else $error("idle");
  a_unmapped_zero: assert property (disable iff (srst) read && !waitrequest && address > 4'h8
    |-> readdata == 32'h0) else $error("unmapped");
  a_init_out: assert property (srst |=> !pad_out) else $error("init");
  a_oe_reset: assert property (srst |=> !pad_oe) else $error("oe reset");
  a_oe_release: assert property (disable iff (srst) $fell(srst) |-> ##[0:1] pad_oe) else $error("oe");
  a_cap_reset: assert property (srst |=> !in_capture_r) else $error("cap");
  c_tri: cover property (pad_oe ##1 !pad_oe);
  c_read: cover property (read && !waitrequest);
  c_out: cover property ($rose(pad_out));
endmodule // io_out_chk
bind io_output_path_register io_out_chk u_chk(.clk(clk), .srst(srst), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .pad_out(pad_out), .pad_oe(pad_oe), .in_capture_r(in_capture_r));

// >>> dv/io_output_path_register_bench.sv
// Purpose: table of pad cases. Assumes: srst sync. Notes: reads STAT too
`timescale 1ns/1ps
module io_output_path_register_bench;
  logic clk = 0, srst = 1, read = 0, write = 0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, rd;
  wire [31:0] readdata;
  wire waitrequest, pad_in, pad_out, pad_oe, in_capture_r;
  int num_errors = 0, num_checks = 0;
  logic [5:0] cfg [8] = '{6'h00, 6'h01, 6'h00, 6'h02, 6'h14, 6'h14, 6'h04, 6'h0C};
  logic [5:0] ctl [8] = '{6'h00, 6'h00, 6'h12, 6'h00, 6'h01, 6'h08, 6'h20, 6'h20};
  logic [1:0] want [8] = '{2'h2, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 2'h2, 2'h3};
  always #5 clk = ~clk;
  io_output_path_register i_dut(.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .in_capture_r(in_capture_r));
  pad_model u_pad(.pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in));
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    address <= a; writedata <= d; write <= w; read <= !w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata; write <= 0; read <= 0;
    @(posedge clk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin num_errors++; $display("CHECK FAILED %0t %h %h", $time, g, e); end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      acc(1, 4'h0, {26'h0, cfg[i]});
      acc(1, 4'h4, {26'h0, ctl[i]});
      repeat (3) @(posedge clk);
      chk({30'h0, pad_oe, pad_out}, {30'h0, want[i]});
      acc(0, 4'h8, 32'h0);
      chk({30'h0, rd[1:0]}, {30'h0, want[i]});
    end
    acc(0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    acc(0, 4'h0, 32'h0);
    chk(rd, 32'h0000_000C);
    acc(0, 4'h4, 32'h0);
    chk(rd, 32'h0000_0020);
    acc(1, 4'h0, 32'h0000_0021);
    acc(1, 4'h4, 32'h0000_0000);
    repeat (5) @(posedge clk);
    acc(0, 4'h8, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h0000_000F);
    acc(1, 4'h4, 32'h0000_0008);
    acc(1, 4'h0, 32'h0000_0020);
    repeat (5) @(posedge clk);
    chk({31'h0, in_capture_r}, 32'h0000_0001);
    acc(0, 4'h8, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h0000_0006);
    acc(1, 4'h4, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk({31'h0, in_capture_r}, 32'h0000_0000);
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    give_verdict;
  end
endmodule // io_output_path_register_bench
